// ===== drive_cmd_pkg.sv
// Shared constants, register map and types of the run-command arbiter
package drive_cmd_pkg;

	localparam int FREQ_W = 16;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] CFG_OFFSET    = 8'h00;
	localparam logic [7:0] RAMP_OFFSET   = 8'h04;
	localparam logic [7:0] MAXF_OFFSET   = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0c;

	// Configuration register fields
	localparam int CFG_SRC_LSB   = 0;
	localparam int CFG_PREV_LSB  = 4;
	localparam int CFG_PON_BIT   = 8;
	localparam int CFG_RST_BIT   = 9;
	localparam int CFG_KEY_LSB   = 12;
	localparam int CFG_RUNEN_BIT = 14;
	localparam int CFG_SS_LSB    = 16;

	// Ramp register fields, times in ramp ticks
	localparam int RAMP_ACC_LSB = 0;
	localparam int RAMP_DEC_LSB = 16;

	// Status register fields
	localparam int ST_REMOTE_BIT = 0;
	localparam int ST_RUN_BIT    = 1;
	localparam int ST_REV_BIT    = 2;
	localparam int ST_TRIP_BIT   = 3;
	localparam int ST_PLOCK_BIT  = 4;
	localparam int ST_TLOCK_BIT  = 5;
	localparam int ST_FREQ_LSB   = 16;

	// Reset values: terminal mode 1, 20.0 s / 30.0 s at 1 ms ticks, 60.00 Hz
	localparam logic [31:0] CFG_RESET  = 32'h0000_0001;
	localparam logic [31:0] RAMP_RESET = 32'h7530_4e20;
	localparam logic [31:0] MAXF_RESET = 32'h0000_1770;

	localparam int SS_TRIP_BIT    = 2;
	localparam int SS_POWERUP_BIT = 4;

	localparam logic [1:0] MULTI_KEY_LOCAL_REMOTE = 2'h1;
	localparam logic [1:0] PREV_NONE = 2'h0;
	localparam logic [1:0] PREV_FWD  = 2'h1;
	localparam logic [1:0] PREV_REV  = 2'h2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Ramp tick period
	localparam int CLK_PERIOD_NS    = 10;
	localparam int TICK_TIME_NS     = 1000000;
	localparam int TICK_CYCLES_DEF  = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		SRC_KEYPAD   = 3'h0,
		SRC_TERM_FR  = 3'h1,
		SRC_TERM_RD  = 3'h2,
		SRC_SERIAL   = 3'h3,
		SRC_FIELDBUS = 3'h4,
		SRC_PLC      = 3'h5
	} cmd_src_t;

	typedef enum logic [2:0] {
		ST_STOP = 3'h1,
		ST_RUN  = 3'h2,
		ST_TRIP = 3'h4
	} run_state_t;

endpackage : drive_cmd_pkg

// ===== ramp_if.sv
// Signals between the arbiter and its ramp generator
`timescale 1ns/1ps
interface ramp_if #(parameter int W = 16);
	logic [W-1:0]  target;
	logic [W-1:0]  max_freq;
	logic [15:0]   accel_ticks;
	logic [15:0]   decel_ticks;
	logic          tick;
	logic          coast;
	logic [W-1:0]  freq;
	modport ctrl (output target, max_freq, accel_ticks, decel_ticks, tick, coast, input freq);
	modport ramp (input target, max_freq, accel_ticks, decel_ticks, tick, coast, output freq);
endinterface : ramp_if

// ===== drive_ramp.sv
// Linear ramp generator with a slope fixed by the maximum frequency
`timescale 1ns/1ps
module drive_ramp
	import drive_cmd_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic  aclk,
	input wire logic  aresetn,
	ramp_if.ramp      rp
);

	if (W < 2) begin : g_bad_width
		$error("W must be at least 2");
	end

	// Zero ticks means an instant jump; a slope below one unit is raised so the ramp still ends
	function automatic logic [W-1:0] slope(input logic [W-1:0] max_f, input logic [15:0] ticks);
		logic [W-1:0] q;
		q = '0;
		if (ticks == 16'h0000) begin
			q = max_f;
		end else begin
			q = W'(max_f / ticks);
			if (q == '0) begin
				q = W'(1);
			end
		end
		return q;
	endfunction : slope

	logic [W-1:0] up_step;
	logic [W-1:0] down_step;

	assign up_step   = slope(rp.max_freq, rp.accel_ticks);
	assign down_step = slope(rp.max_freq, rp.decel_ticks);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rp.freq <= '0;
		end else if (rp.coast) begin
			rp.freq <= '0;
		end else if (rp.tick) begin
			if (rp.freq < rp.target) begin
				rp.freq <= (rp.target - rp.freq > up_step) ? rp.freq + up_step : rp.target;
			end else if (rp.freq > rp.target) begin
				rp.freq <= (rp.freq - rp.target > down_step) ? rp.freq - down_step : rp.target;
			end
		end
	end

	a_ramp_up_step: assert property (@(posedge aclk) disable iff (!aresetn)
		rp.tick && !rp.coast && rp.freq < rp.target |=>
		rp.freq > $past(rp.freq) && rp.freq <= $past(rp.target)
		&& rp.freq - $past(rp.freq) <= $past(up_step))
		else $error("ramp step up wrong");

endmodule : drive_ramp

// ===== drive_run_command_arbiter.sv
// Run-command arbiter: local/remote selection, interlocks, direction guard and ramp
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module drive_run_command_arbiter
	import drive_cmd_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [ADDR_W-1:0]  awaddr,
	input  wire logic               awvalid,
	output logic                    awready,
	input  wire logic [31:0]        wdata,
	input  wire logic [3:0]         wstrb,
	input  wire logic               wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire logic               bready,
	input  wire logic [ADDR_W-1:0]  araddr,
	input  wire logic               arvalid,
	output logic                    arready,
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire logic               rready,
	input  wire logic               keypad_fwd,
	input  wire logic               keypad_rev,
	input  wire logic               keypad_stop,
	input  wire logic               multi_key_press,
	input  wire logic [FREQ_W-1:0]  keypad_freq,
	input  wire logic               run_forward_input,
	input  wire logic               run_reverse_input,
	input  wire logic               jog_forward_input,
	input  wire logic               jog_reverse_input,
	input  wire logic               premagnetize_input,
	input  wire logic               run_enable_input,
	input  wire logic               digital_run,
	input  wire logic               digital_reverse,
	input  wire logic               digital_stop,
	input  wire logic [FREQ_W-1:0]  remote_freq,
	input  wire logic               trip_fault,
	input  wire logic               trip_reset,
	output logic                    run_active,
	output logic                    run_reverse,
	output logic                    output_cut,
	output logic                    speed_search,
	output logic                    remote_indicator,
	output logic [2:0]              shown_cmd_source,
	output logic [FREQ_W-1:0]       output_freq
);

	if (TICK_CYCLES < 1 || FREQ_W > 16) begin : g_bad_params
		$error("TICK_CYCLES must be at least 1 and FREQ_W at most 16");
	end

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_strb

	logic [31:0]  cfg;
	logic [31:0]  ramp_cfg;
	logic [31:0]  maxf_cfg;
	run_state_t   state;
	run_state_t   next_state;
	logic         remote;
	logic         powered;
	logic         cfg_loaded;
	logic         power_lock;
	logic         trip_lock;
	logic         local_run;
	logic         local_rev;
	logic         dig_run;
	logic         dig_rev;
	logic         applied_rev;
	logic [31:0]  tick_count;
	logic         tick;

	ramp_if #(.W(FREQ_W)) rif ();

	drive_ramp #(.W(FREQ_W)) u_ramp (
		.aclk    (aclk),
		.aresetn (aresetn),
		.rp      (rif.ramp)
	);

	// Configuration fields
	cmd_src_t    src;
	logic [1:0]  prevent;
	logic        power_on_run;
	logic        rst_restart;
	logic [1:0]  multi_key_sel;
	logic        run_en_assigned;
	logic [7:0]  ss_cfg;

	assign src             = cmd_src_t'(cfg[CFG_SRC_LSB +: 3]);
	assign prevent         = cfg[CFG_PREV_LSB +: 2];
	assign power_on_run    = cfg[CFG_PON_BIT];
	assign rst_restart     = cfg[CFG_RST_BIT];
	assign multi_key_sel   = cfg[CFG_KEY_LSB +: 2];
	assign run_en_assigned = cfg[CFG_RUNEN_BIT];
	assign ss_cfg          = cfg[CFG_SS_LSB +: 8];

	// Command decode
	logic  is_terminal;
	logic  term_run;
	logic  term_rev;
	logic  any_run_input;
	logic  key_toggle;
	logic  want_run;
	logic  want_rev;
	logic  blocked;
	logic  allowed_run;
	logic  restart_ok;
	logic  powerup_start;

	assign is_terminal   = (src == SRC_TERM_FR) || (src == SRC_TERM_RD);
	assign any_run_input = run_forward_input | run_reverse_input | jog_forward_input
		| jog_reverse_input | premagnetize_input;
	assign key_toggle    = multi_key_press && (multi_key_sel == MULTI_KEY_LOCAL_REMOTE);

	always_comb begin
		if (src == SRC_TERM_FR) begin
			term_run = run_forward_input ^ run_reverse_input;
			term_rev = run_reverse_input;
		end else begin
			term_run = run_forward_input;
			term_rev = run_reverse_input;
		end
	end

	// Jog inputs only count toward the power-up and trip interlocks; they never start a run
	always_comb begin
		if (!remote) begin
			want_run = local_run && (!run_en_assigned || run_enable_input);
			want_rev = local_rev;
		end else if (is_terminal) begin
			want_run = term_run && !power_lock && !trip_lock
				&& (powered || (cfg_loaded && power_on_run));
			want_rev = term_rev;
		end else begin
			want_run = dig_run;
			want_rev = dig_rev;
		end
	end

	assign blocked     = (prevent == PREV_FWD && !want_rev) || (prevent == PREV_REV && want_rev);
	assign allowed_run = want_run && !blocked;
	assign restart_ok  = rst_restart && remote && is_terminal && term_run && !power_lock && !trip_lock
		&& !blocked;
	assign powerup_start = cfg_loaded && !powered && power_on_run && remote && is_terminal && term_run
		&& !blocked;

	always_comb begin
		next_state = state;
		case (state)
			ST_STOP, ST_RUN: begin
				next_state = allowed_run ? ST_RUN : ST_STOP;
				if (key_toggle && (remote || !is_terminal)) begin
					next_state = ST_STOP;
				end
			end
			ST_TRIP: begin
				if (trip_reset && !trip_fault) begin
					next_state = restart_ok ? ST_RUN : ST_STOP;
				end
			end
			default: next_state = ST_STOP;
		endcase
		if (trip_fault) begin
			next_state = ST_TRIP;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_STOP;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remote <= 1'b1;
		end else if (key_toggle) begin
			remote <= !remote;
		end
	end

	// Configuration resets with the drive, so the power-up decision waits until software loads it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			powered    <= 1'b0;
			power_lock <= 1'b0;
		end else if (cfg_loaded) begin
			powered <= 1'b1;
			if (!powered) begin
				power_lock <= any_run_input && !power_on_run;
			end else if (!any_run_input) begin
				power_lock <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trip_lock <= 1'b0;
		end else if (state == ST_TRIP && trip_reset && !trip_fault && !restart_ok) begin
			trip_lock <= 1'b1;
		end else if (!any_run_input) begin
			trip_lock <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			local_run <= 1'b0;
			local_rev <= 1'b0;
		end else if ((key_toggle && remote) || trip_fault || keypad_stop) begin
			local_run <= 1'b0;
		end else if (!remote && keypad_fwd) begin
			local_run <= 1'b1;
			local_rev <= 1'b0;
		end else if (!remote && keypad_rev) begin
			local_run <= 1'b1;
			local_rev <= 1'b1;
		end else if (!remote && run_en_assigned && !run_enable_input) begin
			local_run <= 1'b0;
		end
	end

	// Keypad as remote source behaves as a digital source
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dig_run <= 1'b0;
			dig_rev <= 1'b0;
		end else if ((key_toggle && !remote) || trip_fault) begin
			dig_run <= 1'b0;
		end else if (src == SRC_KEYPAD) begin
			if (keypad_stop) begin
				dig_run <= 1'b0;
			end else if (keypad_fwd || keypad_rev) begin
				dig_run <= 1'b1;
				dig_rev <= keypad_rev;
			end
		end else if (digital_stop) begin
			dig_run <= 1'b0;
		end else if (digital_run) begin
			dig_run <= 1'b1;
			dig_rev <= digital_reverse;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			speed_search <= 1'b0;
		end else begin
			speed_search <= (powerup_start && !trip_fault && ss_cfg[SS_POWERUP_BIT])
				|| (state == ST_TRIP && trip_reset && !trip_fault && restart_ok && ss_cfg[SS_TRIP_BIT]);
		end
	end

	// Direction only flips at standstill, so a reversal ramps down first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			applied_rev <= 1'b0;
		end else if (rif.freq == '0 && state == ST_RUN) begin
			applied_rev <= want_rev;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_count <= '0;
		end else if (tick) begin
			tick_count <= '0;
		end else begin
			tick_count <= tick_count + 32'h1;
		end
	end

	assign tick = (tick_count == 32'(TICK_CYCLES - 1));

	logic [FREQ_W-1:0] sel_freq;
	logic [FREQ_W-1:0] capped_freq;

	assign sel_freq    = remote ? remote_freq : keypad_freq;
	assign capped_freq = (sel_freq > rif.max_freq) ? rif.max_freq : sel_freq;

	assign rif.target      = (state == ST_RUN && want_rev == applied_rev) ? capped_freq : '0;
	assign rif.max_freq    = maxf_cfg[FREQ_W-1:0];
	assign rif.accel_ticks = ramp_cfg[RAMP_ACC_LSB +: 16];
	assign rif.decel_ticks = ramp_cfg[RAMP_DEC_LSB +: 16];
	assign rif.tick        = tick;
	assign rif.coast       = (state == ST_TRIP);

	assign run_active       = (state == ST_RUN);
	assign output_cut       = (state == ST_TRIP);
	assign run_reverse      = applied_rev;
	assign remote_indicator = remote;
	assign output_freq      = rif.freq;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shown_cmd_source <= SRC_KEYPAD;
		end else begin
			shown_cmd_source <= remote ? src : SRC_KEYPAD;
		end
	end

	// AXI4-Lite slave; address and data are taken together in one cycle
	logic        wr_go;
	logic [7:0]  wr_addr;
	logic [7:0]  rd_addr;
	logic [31:0] status_word;

	assign wr_go   = awvalid && wvalid && !bvalid;
	assign awready = wr_go;
	assign wready  = wr_go;
	assign arready = !rvalid;
	assign wr_addr = {awaddr[7:2], 2'b00};
	assign rd_addr = {araddr[7:2], 2'b00};

	assign status_word = {output_freq, 10'h000, trip_lock, power_lock, output_cut,
		applied_rev, run_active, remote};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg      <= CFG_RESET;
			ramp_cfg <= RAMP_RESET;
			maxf_cfg <= MAXF_RESET;
		end else if (wr_go) begin
			case (wr_addr)
				CFG_OFFSET:  cfg      <= merge_strb(cfg, wdata, wstrb);
				RAMP_OFFSET: ramp_cfg <= merge_strb(ramp_cfg, wdata, wstrb);
				MAXF_OFFSET: maxf_cfg <= merge_strb(maxf_cfg, wdata, wstrb);
				default: ;
			endcase
		end
	end

	// Terminal runs stay refused until the first configuration write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_loaded <= 1'b0;
		end else if (wr_go && wr_addr == CFG_OFFSET) begin
			cfg_loaded <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= (wr_addr == CFG_OFFSET || wr_addr == RAMP_OFFSET || wr_addr == MAXF_OFFSET)
				? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= RESP_OKAY;
			case (rd_addr)
				CFG_OFFSET:    rdata <= cfg;
				RAMP_OFFSET:   rdata <= ramp_cfg;
				MAXF_OFFSET:   rdata <= maxf_cfg;
				STATUS_OFFSET: rdata <= status_word;
				default: begin
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	sequence s_trip_cut;
		state == ST_TRIP ##1 output_freq == '0;
	endsequence

	sequence s_searched_start;
		speed_search && state == ST_RUN ##1 !speed_search;
	endsequence

	a_local_jog_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		!remote && state == ST_STOP && !local_run && !keypad_fwd && !keypad_rev |=> state != ST_RUN)
		else $error("local run started without keypad command");

	a_run_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!remote && run_en_assigned && !run_enable_input |=> state != ST_RUN)
		else $error("local run without run-enable input");

	a_key_toggles_mode: assert property (@(posedge aclk) disable iff (!aresetn)
		key_toggle |=> remote != $past(remote) && remote_indicator == remote)
		else $error("multi-key press did not toggle mode");

	a_to_local_stops: assert property (@(posedge aclk) disable iff (!aresetn)
		key_toggle && remote |=> state != ST_RUN ##1 shown_cmd_source == SRC_KEYPAD)
		else $error("entering local did not stop or show keypad");

	a_digital_remote_stops: assert property (@(posedge aclk) disable iff (!aresetn)
		key_toggle && !remote && !is_terminal |=> state != ST_RUN)
		else $error("remote digital source kept running");

	a_power_lock_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		remote && is_terminal && power_lock |=> state != ST_RUN)
		else $error("terminal run accepted under power-up interlock");

	a_trip_lock_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		remote && is_terminal && trip_lock |=> state != ST_RUN)
		else $error("terminal run accepted before release after trip");

	a_direction_guard: assert property (@(posedge aclk) disable iff (!aresetn)
		blocked |=> state != ST_RUN)
		else $error("run in prevented direction");

	a_powerup_search: assert property (@(posedge aclk) disable iff (!aresetn)
		powerup_start && !trip_fault && ss_cfg[SS_POWERUP_BIT] |=> s_searched_start)
		else $error("power-up start without speed search");

	a_trip_coasts: assert property (@(posedge aclk) disable iff (!aresetn)
		trip_fault |=> s_trip_cut)
		else $error("trip did not cut output");

	a_restart_search: assert property (@(posedge aclk) disable iff (!aresetn)
		state == ST_TRIP && trip_reset && !trip_fault && restart_ok && ss_cfg[SS_TRIP_BIT]
		|=> s_searched_start)
		else $error("trip restart without speed search");

	a_mode1_agree_stops: assert property (@(posedge aclk) disable iff (!aresetn)
		remote && src == SRC_TERM_FR && run_forward_input == run_reverse_input
		&& state != ST_TRIP && !trip_fault |=> state == ST_STOP)
		else $error("terminal mode 1 ran with equal inputs");

endmodule : drive_run_command_arbiter

// ===== drive_field_model.sv
// Stand-in for the operator keypad and the terminal block
`timescale 1ns/1ps
module drive_field_model (
	input  wire logic       aclk,
	input  wire logic [4:0] term_req,
	input  wire logic [3:0] key_req,
	output logic      [4:0] term = 5'h00,
	output logic      [3:0] keys = 4'h0
);
	// Contacts change just after an edge, so a key press is exactly one cycle wide
	always @(posedge aclk) begin
		term <= term_req;
		keys <= key_req;
	end
endmodule : drive_field_model

// ===== drive_run_command_arbiter_tb.sv
// Self-checking bench for the run-command arbiter
`timescale 1ns/1ps
module drive_run_command_arbiter_tb import drive_cmd_pkg::*;;
	logic        aclk = 1'b0;
	logic        aresetn, awvalid, wvalid, bready, arvalid, rready, trip_fault, trip_reset, run_enable_input;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, d;
	logic [3:0]  wstrb, key_req;
	logic [4:0]  term_req;
	logic [15:0] keypad_freq, remote_freq;
	logic [1:0]  r;
	logic [2:0]  dig_req;
	wire logic   awready, wready, bvalid, arready, rvalid, run_active, run_reverse, output_cut, speed_search;
	wire logic   remote_indicator, keypad_fwd, keypad_rev, keypad_stop, multi_key_press;
	wire logic   run_forward_input, run_reverse_input, jog_forward_input, jog_reverse_input, premagnetize_input;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [2:0]  shown_cmd_source;
	wire logic [15:0] output_freq;
	wire logic [4:0]  term;
	wire logic [3:0]  keys;
	int n_errors = 0;
	int tests_run = 0;
	always #5 aclk = ~aclk;
	assign {premagnetize_input, jog_reverse_input, jog_forward_input, run_reverse_input, run_forward_input} = term;
	assign {multi_key_press, keypad_stop, keypad_rev, keypad_fwd} = keys;
	drive_field_model i_drive_field_model (.aclk, .term_req, .key_req, .term, .keys);
	drive_run_command_arbiter #(.TICK_CYCLES(4)) i_drive_run_command_arbiter (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .keypad_fwd, .keypad_rev, .keypad_stop, .multi_key_press, .keypad_freq,
		.run_forward_input, .run_reverse_input, .jog_forward_input, .jog_reverse_input, .premagnetize_input,
		.run_enable_input, .digital_run(dig_req[0]), .digital_reverse(dig_req[1]), .digital_stop(dig_req[2]),
		.remote_freq,
		.trip_fault, .trip_reset, .run_active, .run_reverse, .output_cut, .speed_search, .remote_indicator,
		.shown_cmd_source, .output_freq);
	task automatic test_done;
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [15:0] pick(input int s);
		case (s)
			0: return run_active;
			1: return output_cut;
			2: return remote_indicator;
			3: return speed_search;
			4: return run_reverse;
			5: return awready;
			6: return bvalid;
			7: return arready;
			8: return rvalid;
			default: return output_freq;
		endcase
	endfunction : pick
	// Bounded wait; a miss ends the run at once
	task automatic wait_for(input string what, input int s, input logic [15:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			if (pick(s) === v) break;
		end
		chk(what, pick(s), v);
		if (pick(s) !== v) test_done;
	endtask : wait_for
	task automatic stays_off(input string what, input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge aclk);
			if (run_active !== 1'b0) seen = 1'b1;
		end
		chk(what, seen, 1'b0);
	endtask : stays_off
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		wait_for("aw taken", 5, 1, 50);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		wait_for("bvalid", 6, 1, 50);
		r = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		wait_for("ar taken", 7, 1, 50);
		arvalid <= 1'b0;
		wait_for("rvalid", 8, 1, 50);
		d = rdata;
		r = rresp;
	endtask : rd
	task automatic press(input logic [3:0] k);
		key_req <= k;
		@(posedge aclk);
		key_req <= 4'h0;
		@(posedge aclk);
	endtask : press
	task automatic dig_pulse(input logic [2:0] v);
		dig_req <= v;
		@(posedge aclk);
		dig_req <= 3'h0;
	endtask : dig_pulse
	task automatic trip_cycle;
		trip_fault <= 1'b1;
		wait_for("coast", 1, 1, 4);
		trip_fault <= 1'b0;
		@(posedge aclk);
		trip_reset <= 1'b1;
		@(posedge aclk);
		trip_reset <= 1'b0;
	endtask : trip_cycle
	task automatic t_registers;
		rd(CFG_OFFSET);
		chk("cfg", d, CFG_RESET);
		rd(RAMP_OFFSET);
		chk("ramp", d, RAMP_RESET);
		rd(MAXF_OFFSET);
		chk("maxf", d, MAXF_RESET);
		rd(8'h10);
		chk("unmapped", r, RESP_SLVERR);
		for (int k = 5; k >= 0; k--) begin
			wr(CFG_OFFSET, k);
			@(posedge aclk);
			chk("source", shown_cmd_source, k);
		end
		wr(STATUS_OFFSET, 32'hffff_ffff);
		chk("ro write", r, RESP_SLVERR);
		rd(STATUS_OFFSET);
		chk("plock", d[ST_PLOCK_BIT], 1'b1);
	endtask : t_registers
	task automatic t_ramp;
		wr(MAXF_OFFSET, 32'h0000_0064);
		wr(RAMP_OFFSET, 32'h000a_000a);
		stays_off("power lock", 20);
		term_req <= 5'h00;
		repeat (4) @(posedge aclk);
		term_req <= 5'h01;
		wait_for("run", 0, 1, 8);
		wait_for("step", 9, 16'h000a, 12);
		wait_for("full", 9, 16'h0064, 44);
		term_req <= 5'h03;
		wait_for("both", 0, 0, 80);
		term_req <= 5'h00;
		wait_for("zero", 9, 0, 60);
	endtask : t_ramp
	task automatic t_prevent;
		wr(CFG_OFFSET, 32'h0000_0011);
		term_req <= 5'h01;
		stays_off("fwd inhibit", 20);
		term_req <= 5'h02;
		wait_for("rev ok", 4, 1, 20);
		term_req <= 5'h00;
		wait_for("zero", 9, 0, 80);
		wr(CFG_OFFSET, 32'h0000_0021);
		term_req <= 5'h02;
		stays_off("rev inhibit", 20);
		wr(CFG_OFFSET, 32'h0000_0002);
		term_req <= 5'h01;
		wait_for("mode2 fwd", 4, 0, 80);
		term_req <= 5'h03;
		wait_for("mode2 rev", 4, 1, 120);
		term_req <= 5'h00;
		wait_for("zero", 9, 0, 80);
	endtask : t_prevent
	task automatic t_local;
		wr(CFG_OFFSET, 32'h0000_5001);
		term_req <= 5'h01;
		wait_for("remote run", 0, 1, 8);
		press(4'h8);
		wait_for("L shown", 2, 0, 4);
		wait_for("stop", 0, 0, 80);
		chk("keypad src", shown_cmd_source, 3'h0);
		run_enable_input <= 1'b0;
		press(4'h1);
		stays_off("run enable", 16);
		run_enable_input <= 1'b1;
		term_req <= 5'h04;
		stays_off("jog", 16);
		press(4'h1);
		wait_for("keypad run", 0, 1, 8);
		term_req <= 5'h02;
		press(4'h8);
		wait_for("R shown", 2, 1, 4);
		@(posedge aclk);
		chk("term src", shown_cmd_source, 3'h1);
		wait_for("follow", 4, 1, 120);
		term_req <= 5'h00;
		wait_for("zero", 9, 0, 80);
	endtask : t_local
	task automatic t_digital;
		wr(CFG_OFFSET, 32'h0000_1003);
		dig_pulse(3'h1);
		wait_for("serial run", 0, 1, 8);
		press(4'h8);
		wait_for("local stop", 0, 0, 8);
		press(4'h1);
		wait_for("local run", 0, 1, 8);
		press(4'h8);
		wait_for("remote stop", 0, 0, 8);
		stays_off("no command", 8);
		dig_pulse(3'h1);
		wait_for("next command", 0, 1, 8);
		dig_pulse(3'h4);
		wait_for("digital stop", 0, 0, 8);
	endtask : t_digital
	task automatic t_powerup;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		stays_off("before load", 4);
		wr(CFG_OFFSET, 32'h0010_0101);
		wait_for("auto search", 3, 1, 4);
		chk("auto run", run_active, 1'b1);
	endtask : t_powerup
	task automatic t_trip;
		wr(CFG_OFFSET, 32'h0004_1201);
		term_req <= 5'h01;
		wait_for("run", 0, 1, 8);
		trip_cycle;
		wait_for("search", 3, 1, 8);
		chk("resumed", run_active, 1'b1);
		wr(CFG_OFFSET, 32'h0000_1001);
		trip_cycle;
		stays_off("trip lock", 20);
		term_req <= 5'h00;
		repeat (4) @(posedge aclk);
		term_req <= 5'h01;
		wait_for("rerun", 0, 1, 8);
	endtask : t_trip
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, trip_fault, trip_reset} = '0;
		{awaddr, araddr, wdata, wstrb, key_req, dig_req} = '0;
		run_enable_input = 1'b1;
		keypad_freq = 16'h0064;
		remote_freq = 16'h0064;
		// Held at power-up to arm the start interlock
		term_req = 5'h01;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_registers;
		wr(CFG_OFFSET, 32'h0000_0001);
		t_ramp;
		t_prevent;
		t_local;
		t_digital;
		t_trip;
		t_powerup;
		test_done;
	end
endmodule : drive_run_command_arbiter_tb
